// ==== dcbo_block_ops.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcbo_block_ops #(
	parameter int unsigned LINES = 4
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output dcbo_pkg::dcbo_mem_req_t mem_req,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	output logic irq
);
	localparam int unsigned IW = $clog2(LINES);
	localparam int unsigned TW = 32 - dcbo_pkg::OFF_W - IW;
	localparam int unsigned LW = 32 - dcbo_pkg::OFF_W;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_WB,
		ST_FILL,
		ST_ZERO,
		ST_DONE
	} dcbo_state_t;

	function automatic logic [IW+2:0] word_at(
		input logic [IW-1:0] line,
		input logic [2:0] w
	);
		return {line, w};
	endfunction

	function automatic logic reg_known(input logic [7:0] a);
		case (a)
			dcbo_pkg::REG_CMD, dcbo_pkg::REG_BASE, dcbo_pkg::REG_INDEX,
			dcbo_pkg::REG_ATTR, dcbo_pkg::REG_CFG, dcbo_pkg::REG_DAC,
			dcbo_pkg::REG_STATUS, dcbo_pkg::REG_EA, dcbo_pkg::REG_PEEK,
			dcbo_pkg::REG_IRQ_STS, dcbo_pkg::REG_IRQ_MASK:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction

	dcbo_state_t state;
	dcbo_state_t next_state;
	logic [2:0] cmd_op;
	logic [4:0] base_register_field;
	logic [31:0] base_val;
	logic [31:0] index_register;
	dcbo_pkg::dcbo_attr_t attr;
	dcbo_pkg::dcbo_cfg_t core_config_register;
	logic [31:0] dac_addr;
	logic [31:0] effective_address;
	logic [dcbo_pkg::EV_W-1:0] irq_sts;
	logic [dcbo_pkg::EV_W-1:0] irq_msk;
	logic [dcbo_pkg::EV_W-1:0] ev;
	logic [dcbo_pkg::EV_W-1:0] next_ev;
	logic [2:0] wcnt;
	logic [LW-1:0] line_q;
	logic err_q;

	logic [TW-1:0] tag_mem [LINES];
	logic [31:0] data_mem [LINES*dcbo_pkg::WORDS];
	logic [LINES-1:0] vld;
	logic [LINES-1:0] dty;

	logic wr;
	logic start;
	logic [31:0] base_sel;
	logic [IW-1:0] idx;
	logic [TW-1:0] tag;
	logic hit;
	logic victim_dirty;
	logic is_touch;
	logic is_zero;
	logic cmp_store;
	logic tlb_x;
	logic dsi_x;
	logic align_x;
	logic dac_x;
	logic beat;
	logic last_beat;

	// ======================================================
	// Register bus
	assign pready = psel & penable & ce;
	assign pslverr = pready & err_q;
	assign wr = pready & pwrite;
	assign start = wr & (paddr == dcbo_pkg::REG_CMD) & (state == ST_IDLE);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_op <= 3'h0;
			base_register_field <= 5'h00;
			base_val <= 32'h0000_0000;
			index_register <= 32'h0000_0000;
			attr <= dcbo_pkg::ATTR_RESET;
			core_config_register <= dcbo_pkg::CFG_RESET;
			dac_addr <= 32'h0000_0000;
			irq_msk <= 5'h00;
		end
		else if (ce && wr)
		begin
			// Busy command writes are dropped; other bits reserved
			if (start)
			begin
				cmd_op <= pwdata[dcbo_pkg::CMD_OP_LSB +: 3];
				base_register_field <= pwdata[dcbo_pkg::CMD_FIELD_LSB +: 5];
			end
			case (paddr)
				dcbo_pkg::REG_BASE:
					base_val <= pwdata;
				dcbo_pkg::REG_INDEX:
					index_register <= pwdata;
				dcbo_pkg::REG_ATTR:
					attr <= pwdata[7:0];
				dcbo_pkg::REG_CFG:
					core_config_register <= pwdata[2:0];
				dcbo_pkg::REG_DAC:
					dac_addr <= pwdata;
				dcbo_pkg::REG_IRQ_MASK:
					irq_msk <= pwdata[dcbo_pkg::EV_W-1:0];
				default:
					;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			err_q <= 1'b0;
		end
		else if (ce && psel && !penable)
		begin
			err_q <= !reg_known(paddr);
			case (paddr)
				dcbo_pkg::REG_CMD:
					prdata <= {23'h00_0000, base_register_field, 1'b0,
						cmd_op};
				dcbo_pkg::REG_BASE:
					prdata <= base_val;
				dcbo_pkg::REG_INDEX:
					prdata <= index_register;
				dcbo_pkg::REG_ATTR:
					prdata <= {24'h00_0000, attr};
				dcbo_pkg::REG_CFG:
					prdata <= {29'h0000_0000, core_config_register};
				dcbo_pkg::REG_DAC:
					prdata <= dac_addr;
				dcbo_pkg::REG_STATUS:
					prdata <= {28'h000_0000, dty[idx], vld[idx], hit,
						state != ST_IDLE};
				dcbo_pkg::REG_EA:
					prdata <= effective_address;
				dcbo_pkg::REG_PEEK:
					prdata <= data_mem[word_at(idx, effective_address[4:2])];
				dcbo_pkg::REG_IRQ_STS:
					prdata <= {27'h000_0000, irq_sts};
				dcbo_pkg::REG_IRQ_MASK:
					prdata <= {27'h000_0000, irq_msk};
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ======================================================
	// Address formation
	// Field comes with the command write itself, not the previous one
	assign base_sel = (pwdata[dcbo_pkg::CMD_FIELD_LSB +: 5] == 5'h00) ?
		32'h0000_0000 : base_val;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			effective_address <= 32'h0000_0000;
		else if (ce && start)
			effective_address <= base_sel + index_register;
	end

	assign idx = effective_address[dcbo_pkg::OFF_W +: IW];
	assign tag = effective_address[31 -: TW];
	assign hit = vld[idx] & (tag_mem[idx] == tag);
	assign victim_dirty = vld[idx] & dty[idx] & !hit;

	// ======================================================
	// Fault and compare checks
	assign is_touch = (cmd_op == dcbo_pkg::OP_TOUCH) |
		(cmd_op == dcbo_pkg::OP_TOUCH_ST);
	assign is_zero = cmd_op == dcbo_pkg::OP_ZERO;
	// Zero is a store for faults; store-if-modified only for compare
	assign cmp_store = is_zero | (cmd_op == dcbo_pkg::OP_STORE_MOD);
	assign tlb_x = attr.relocate & !attr.xlate_valid;
	assign dsi_x = (attr.relocate &
		((attr.zone_noaccess & attr.user_mode) |
		(is_zero & attr.zone_readonly))) |
		(is_zero & attr.user_defined_attribute &
		core_config_register.user_attr_exception_enable);
	assign align_x = is_zero & !(attr.cacheable & attr.write_back);
	assign dac_x = (effective_address[31:dcbo_pkg::OFF_W] ==
		dac_addr[31:dcbo_pkg::OFF_W]) &
		(cmp_store ? core_config_register.dac_store_en
		: core_config_register.dac_load_en);

	// ======================================================
	// Sequencer
	assign beat = ce & mem_req.valid & mem_ready;
	assign last_beat = beat & (wcnt == dcbo_pkg::WCNT_LAST);

	always_comb
	begin
		next_state = state;
		next_ev = 5'h00;
		case (state)
			ST_IDLE:
				if (start)
					next_state = ST_CHECK;
			ST_CHECK:
			begin
				next_state = ST_DONE;
				if (!is_touch && !is_zero &&
					cmd_op != dcbo_pkg::OP_STORE_MOD)
					next_state = ST_DONE;
				else if (tlb_x || dsi_x)
				begin
					if (!is_touch)
						next_ev[tlb_x ? dcbo_pkg::EV_TLB : dcbo_pkg::EV_DSI] = 1'b1;
				end
				else if (align_x)
					next_ev[dcbo_pkg::EV_ALIGN] = 1'b1;
				else if (dac_x)
					next_ev[dcbo_pkg::EV_DBG] = 1'b1;
				else if (is_touch)
				begin
					if (attr.cacheable && !hit)
						next_state = victim_dirty ? ST_WB : ST_FILL;
				end
				else if (is_zero)
					next_state = (hit || !victim_dirty) ? ST_ZERO
						: ST_WB;
				else if (hit && dty[idx])
					next_state = ST_WB;
			end
			ST_WB:
				if (last_beat)
				begin
					if (is_touch)
						next_state = ST_FILL;
					else if (is_zero)
						next_state = ST_ZERO;
					else
						next_state = ST_DONE;
				end
			ST_FILL:
				if (last_beat)
					next_state = ST_DONE;
			ST_ZERO:
				next_state = ST_DONE;
			ST_DONE:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_IDLE;
		else if (ce)
			state <= next_state;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wcnt <= 3'h0;
		else if (ce && state == ST_CHECK)
			wcnt <= 3'h0;
		else if (beat)
			wcnt <= wcnt + 3'h1;
	end

	// Dirty victim's address first, the new line after its write-back
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			line_q <= '0;
		else if (ce && state == ST_CHECK)
			line_q <= victim_dirty ? {tag_mem[idx], idx}
				: effective_address[31:dcbo_pkg::OFF_W];
		else if (last_beat)
			line_q <= effective_address[31:dcbo_pkg::OFF_W];
	end

	// ======================================================
	// Main memory port
	assign mem_req.valid = (state == ST_WB) | (state == ST_FILL);
	assign mem_req.write = state == ST_WB;
	assign mem_req.addr = {line_q, wcnt, 2'b00};
	assign mem_req.wdata = data_mem[word_at(idx, wcnt)];

	// ======================================================
	// Line storage
	always_ff @(posedge pclk)
	begin
		if (ce && state == ST_FILL && beat)
			data_mem[word_at(idx, wcnt)] <= mem_rdata;
		if (ce && state == ST_ZERO)
			for (int w = 0; w < dcbo_pkg::WORDS; w++)
				data_mem[word_at(idx, 3'(w))] <= 32'h0000_0000;
		if ((ce && state == ST_ZERO) || (state == ST_FILL && last_beat))
			tag_mem[idx] <= tag;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vld <= '0;
			dty <= '0;
		end
		else if (ce)
		begin
			if (state == ST_WB && last_beat)
				dty[idx] <= 1'b0;
			if (state == ST_FILL && last_beat)
			begin
				vld[idx] <= 1'b1;
				dty[idx] <= 1'b0;
			end
			if (state == ST_ZERO)
			begin
				vld[idx] <= 1'b1;
				dty[idx] <= 1'b1;
			end
		end
	end

	// ======================================================
	// Interrupts; a new event wins over a clear
	always_comb
	begin
		ev = (state == ST_CHECK) ? next_ev : 5'h00;
		ev[dcbo_pkg::EV_DONE] = state == ST_DONE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_sts <= 5'h00;
		else if (ce)
			irq_sts <= (irq_sts & ~((wr && paddr == dcbo_pkg::REG_IRQ_STS) ?
				pwdata[dcbo_pkg::EV_W-1:0] : 5'h00)) | ev;
	end

	assign irq = |(irq_sts & irq_msk);

	// ======================================================
	// Checks
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_chk_clean;
		state == ST_CHECK && ce && !tlb_x && !dsi_x && !dac_x;
	endsequence

	sequence s_zero_ok;
		s_chk_clean ##0 is_zero && !align_x;
	endsequence

	AST_EA_FORM: assert property (ce && start |=> effective_address ==
		(base_register_field == 5'h00 ? $past(index_register)
		: $past(base_val) + $past(index_register)))
		else $error("address formed wrongly");
	AST_SIM_WB: assert property (s_chk_clean ##0 cmd_op ==
		dcbo_pkg::OP_STORE_MOD && hit && dty[idx]
		|=> state == ST_WB && mem_req.write)
		else $error("dirty line not written back");
	AST_SIM_CLEAN: assert property (state == ST_WB && last_beat &&
		cmd_op == dcbo_pkg::OP_STORE_MOD |=> state == ST_DONE && !dty[idx])
		else $error("line still modified after store");
	AST_SIM_NOP: assert property (s_chk_clean ##0 cmd_op ==
		dcbo_pkg::OP_STORE_MOD && !(hit && dty[idx]) |=> state == ST_DONE)
		else $error("store-if-modified not a no-op");
	AST_SIM_LOAD: assert property (state == ST_CHECK && ce &&
		cmd_op == dcbo_pkg::OP_STORE_MOD && !tlb_x && !attr.zone_noaccess
		|-> !ev[dcbo_pkg::EV_DSI])
		else $error("store-if-modified faulted as store");
	AST_SIM_DAC: assert property (state == ST_CHECK && ce &&
		cmd_op == dcbo_pkg::OP_STORE_MOD && !tlb_x && !dsi_x && dac_x
		|-> ev[dcbo_pkg::EV_DBG] && core_config_register.dac_store_en)
		else $error("store-if-modified compare wrong");
	AST_TOUCH_FETCH: assert property (s_chk_clean ##0 is_touch &&
		attr.cacheable && !hit && !victim_dirty |=> state == ST_FILL ##0
		!mem_req.write)
		else $error("touch did not fetch");
	AST_TOUCH_SILENT: assert property ((ev[dcbo_pkg::EV_TLB] ||
		ev[dcbo_pkg::EV_DSI]) |-> !is_touch)
		else $error("touch raised a fault");
	AST_TOUCH_DAC: assert property (state == ST_CHECK && ce && is_touch &&
		!tlb_x && !dsi_x && ev[dcbo_pkg::EV_DBG]
		|-> core_config_register.dac_load_en)
		else $error("touch compared as store");
	AST_ZERO_FILL: assert property (state == ST_ZERO && ce |=>
		dty[idx] && vld[idx] && data_mem[word_at(idx, 3'h7)] == 32'h0)
		else $error("zeroed line wrong");
	AST_ZERO_NOREAD: assert property (s_zero_ok ##0 !hit &&
		!victim_dirty |=> state == ST_ZERO ##1 state == ST_DONE)
		else $error("zero allocate touched memory");
	AST_ALIGN: assert property (state == ST_CHECK && ce && is_zero &&
		!tlb_x && !dsi_x && !(attr.cacheable && attr.write_back)
		|-> ev[dcbo_pkg::EV_ALIGN] ##1 state == ST_DONE && $stable(dty))
		else $error("alignment fault missing");
	AST_ZERO_RO: assert property (state == ST_CHECK && ce && is_zero &&
		attr.relocate && attr.xlate_valid && attr.zone_readonly
		|-> ev[dcbo_pkg::EV_DSI])
		else $error("read-only zone not faulted");
	AST_ZERO_U0: assert property (state == ST_CHECK && ce && is_zero &&
		!tlb_x && attr.user_defined_attribute &&
		core_config_register.user_attr_exception_enable |-> ev[dcbo_pkg::EV_DSI])
		else $error("user attribute fault missing");
	AST_VICTIM: assert property ((state == ST_FILL ||
		state == ST_ZERO) |-> !victim_dirty)
		else $error("dirty victim overwritten");
endmodule
`default_nettype wire

// ==== dcbo_pkg.sv ====
// ==========================================================
// Block operation engine constants
package dcbo_pkg;
	localparam int unsigned OFF_W = 5;
	localparam int unsigned WORDS = 8;
	localparam int unsigned WCNT_W = 3;
	localparam logic [2:0] WCNT_LAST = 3'h7;

	// ======================================================
	// Register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_BASE = 8'h04;
	localparam logic [7:0] REG_INDEX = 8'h08;
	localparam logic [7:0] REG_ATTR = 8'h0c;
	localparam logic [7:0] REG_CFG = 8'h10;
	localparam logic [7:0] REG_DAC = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_EA = 8'h1c;
	localparam logic [7:0] REG_PEEK = 8'h20;
	localparam logic [7:0] REG_IRQ_STS = 8'h24;
	localparam logic [7:0] REG_IRQ_MASK = 8'h28;

	// ======================================================
	// Command fields and operation codes
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_FIELD_LSB = 4;
	localparam logic [2:0] OP_STORE_MOD = 3'h1;
	localparam logic [2:0] OP_TOUCH = 3'h2;
	localparam logic [2:0] OP_TOUCH_ST = 3'h3;
	localparam logic [2:0] OP_ZERO = 3'h4;

	// ======================================================
	// Interrupt event bits
	localparam int unsigned EV_W = 5;
	localparam int unsigned EV_DONE = 0;
	localparam int unsigned EV_ALIGN = 1;
	localparam int unsigned EV_DSI = 2;
	localparam int unsigned EV_TLB = 3;
	localparam int unsigned EV_DBG = 4;

	typedef struct packed {
		logic xlate_valid;
		logic zone_readonly;
		logic zone_noaccess;
		logic user_mode;
		logic relocate;
		logic user_defined_attribute;
		logic write_back;
		logic cacheable;
	} dcbo_attr_t;

	typedef struct packed {
		logic dac_store_en;
		logic dac_load_en;
		logic user_attr_exception_enable;
	} dcbo_cfg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dcbo_mem_req_t;

	localparam dcbo_attr_t ATTR_RESET = 8'h00;
	localparam dcbo_cfg_t CFG_RESET = 3'h0;
endpackage

// ==== dcbo_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Main memory behind the block: 1 KiB of words
module dcbo_mem_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic slow,
	input wire dcbo_pkg::dcbo_mem_req_t mem_req,
	output logic mem_ready,
	output logic [31:0] mem_rdata,
	output int fills,
	output int wbs
);
	logic [31:0] mem [0:255];
	logic [31:0] last;
	logic beat;

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 32'h5a000000 | i;
	end

	assign beat = mem_req.valid & mem_ready & ce;
	// Outside a fill beat the data lines show a changing value
	assign mem_rdata = (mem_ready & mem_req.valid & ~mem_req.write) ?
		mem[mem_req.addr[9:2]] : ~last;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ready <= 1'b0;
			last <= 32'h0;
			fills <= 0;
			wbs <= 0;
		end
		else
		begin
			// Slow mode answers every other cycle
			mem_ready <= slow ? ~mem_ready : 1'b1;
			if (beat && mem_req.write)
			begin
				mem[mem_req.addr[9:2]] <= mem_req.wdata;
				wbs <= wbs + 1;
			end
			else if (beat)
			begin
				last <= mem[mem_req.addr[9:2]];
				fills <= fills + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("wrong value %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic slow = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire logic pready;
	wire logic pslverr;
	wire logic irq;
	wire logic mem_ready;
	wire logic [31:0] prdata;
	wire logic [31:0] mem_rdata;
	wire dcbo_pkg::dcbo_mem_req_t mem_req;
	int fills;
	int wbs;
	int errors = 0;
	int compares = 0;
	int f0;
	int w0;
	logic [31:0] r;
	logic [31:0] s;
	logic er;
	localparam logic [31:0] C_SM = {29'h0, dcbo_pkg::OP_STORE_MOD};
	localparam logic [31:0] C_TCH = {29'h0, dcbo_pkg::OP_TOUCH};
	localparam logic [31:0] C_TST = {29'h0, dcbo_pkg::OP_TOUCH_ST};
	localparam logic [31:0] C_ZERO = {29'h0, dcbo_pkg::OP_ZERO};

	always #2.5 pclk = ~pclk;

	dcbo_block_ops u_dcbo_block_ops (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .mem_req(mem_req), .mem_ready(mem_ready),
		.mem_rdata(mem_rdata), .irq(irq));
	dcbo_mem_model u_dcbo_mem_model (.pclk(pclk), .presetn(presetn),
		.ce(ce), .slow(slow), .mem_req(mem_req), .mem_ready(mem_ready),
		.mem_rdata(mem_rdata), .fills(fills), .wbs(wbs));

	// ======================================================
	// Closing and bus tasks
	task automatic summarize();
		$display("counts: compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			errors++;
			summarize();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] x,
		input string nm);
		logic [31:0] v;
		logic e;
		apb(1'b0, a, 32'h0, v, e);
		`CHK(nm, x, v)
	endtask

	// Starts one operation, waits for idle, returns and clears events
	task automatic op_run(input logic [31:0] cmd, input logic [7:0] attr,
		input logic [31:0] idx, output logic [31:0] st);
		logic [31:0] v;
		logic e;
		int n;
		wr(dcbo_pkg::REG_ATTR, {24'h0, attr});
		wr(dcbo_pkg::REG_INDEX, idx);
		wr(dcbo_pkg::REG_CMD, cmd);
		// Busy may not show on the first read after the command
		repeat (3) @(posedge pclk);
		n = 0;
		do
		begin
			apb(1'b0, dcbo_pkg::REG_STATUS, 32'h0, v, e);
			n++;
		end
		while (v[0] !== 1'b0 && n < 200);
		if (n >= 200)
		begin
			errors++;
			summarize();
		end
		apb(1'b0, dcbo_pkg::REG_IRQ_STS, 32'h0, st, e);
		wr(dcbo_pkg::REG_IRQ_STS, 32'h1f);
	endtask

	task automatic fault_case(input logic [31:0] cmd, input logic [7:0] attr,
		input logic [2:0] cfg, input logic [4:0] x);
		logic [31:0] st;
		int b;
		wr(dcbo_pkg::REG_CFG, {29'h0, cfg});
		b = fills + wbs;
		op_run(cmd, attr, 32'h300, st);
		`CHK("fault bits", {27'h0, x}, st & 32'h1e)
		`CHK("beats", 32'(b), 32'(fills + wbs))
	endtask

	initial
	begin
		#50000;
		errors++;
		summarize();
	end

	// ======================================================
	// Tests
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(dcbo_pkg::REG_STATUS, 32'h0, "status reset");
		chk(dcbo_pkg::REG_IRQ_STS, 32'h0, "irq status reset");
		chk(dcbo_pkg::REG_IRQ_MASK, 32'h0, "irq mask reset");
		apb(1'b0, 8'h30, 32'h0, r, er);
		`CHK("unmapped data", 32'h0, r)
		`CHK("unmapped err", 32'h1, {31'h0, er})
		$display("test reset done");

		wr(dcbo_pkg::REG_BASE, 32'h100);
		op_run(32'h80000030, 8'h00, 32'h24, s);
		chk(dcbo_pkg::REG_EA, 32'h124, "ea with base");
		chk(dcbo_pkg::REG_CMD, 32'h30, "cmd field");
		`CHK("reserved bits events", 32'h1, s)
		op_run(32'h0, 8'h00, 32'h24, s);
		chk(dcbo_pkg::REG_EA, 32'h24, "ea zero base");
		wr(dcbo_pkg::REG_IRQ_MASK, 32'h1);
		wr(dcbo_pkg::REG_CMD, 32'h0);
		// Clock enable low must hold the started operation
		ce <= 1'b0;
		repeat (10) @(posedge pclk);
		`CHK("irq frozen", 32'h0, {31'h0, irq})
		ce <= 1'b1;
		repeat (10) @(posedge pclk);
		`CHK("irq raised", 32'h1, {31'h0, irq})
		wr(dcbo_pkg::REG_IRQ_STS, 32'h1);
		@(posedge pclk);
		`CHK("irq cleared", 32'h0, {31'h0, irq})
		wr(dcbo_pkg::REG_CMD, 32'h0);
		repeat (10) @(posedge pclk);
		wr(dcbo_pkg::REG_IRQ_MASK, 32'h0);
		@(posedge pclk);
		`CHK("irq masked", 32'h0, {31'h0, irq})
		wr(dcbo_pkg::REG_IRQ_STS, 32'h1f);
		$display("test address and interrupt done");

		f0 = fills;
		op_run(C_TCH, 8'h01, 32'h44, s);
		`CHK("fill beats", 32'(f0 + 8), 32'(fills))
		chk(dcbo_pkg::REG_PEEK, 32'h5a000011, "fill word");
		chk(dcbo_pkg::REG_STATUS, 32'h6, "touch status");
		op_run(C_TCH, 8'h01, 32'h44, s);
		`CHK("resident touch", 32'(f0 + 8), 32'(fills))
		op_run(C_TST, 8'h00, 32'h64, s);
		`CHK("uncached touch", 32'(f0 + 8), 32'(fills))
		slow <= 1'b1;
		op_run(C_TST, 8'h01, 32'h64, s);
		slow <= 1'b0;
		`CHK("slow fill beats", 32'(f0 + 16), 32'(fills))
		chk(dcbo_pkg::REG_PEEK, 32'h5a000019, "slow fill word");
		$display("test touch done");

		// Zeroed lines stay inside the modelled memory
		f0 = fills;
		w0 = wbs;
		op_run(C_ZERO, 8'h03, 32'h44, s);
		chk(dcbo_pkg::REG_PEEK, 32'h0, "zeroed word");
		chk(dcbo_pkg::REG_STATUS, 32'he, "zero dirty");
		op_run(C_ZERO, 8'h03, 32'h04, s);
		chk(dcbo_pkg::REG_STATUS, 32'he, "alloc dirty");
		`CHK("alloc no beats", 32'(f0 + w0), 32'(fills + wbs))
		op_run(C_TCH, 8'h01, 32'h84, s);
		`CHK("victim beats", 32'(w0 + 8), 32'(wbs))
		`CHK("victim data", 32'h0, u_dcbo_mem_model.mem[1])
		chk(dcbo_pkg::REG_PEEK, 32'h5a000021, "refill word");
		$display("test zero done");

		w0 = wbs;
		op_run(C_SM, 8'h00, 32'h44, s);
		`CHK("store beats", 32'(w0 + 8), 32'(wbs))
		`CHK("stored word", 32'h0, u_dcbo_mem_model.mem[17])
		chk(dcbo_pkg::REG_STATUS, 32'h6, "store clean");
		op_run(C_SM, 8'h00, 32'h44, s);
		`CHK("clean no store", 32'(w0 + 8), 32'(wbs))
		op_run(C_SM, 8'h00, 32'h1e4, s);
		`CHK("absent no store", 32'(w0 + 8), 32'(wbs))
		chk(dcbo_pkg::REG_STATUS, 32'h4, "absent status");
		$display("test store done");

		op_run(C_ZERO, 8'h01, 32'h64, s);
		`CHK("write-through", 32'h2, s & 32'h1e)
		chk(dcbo_pkg::REG_PEEK, 32'h5a000019, "line kept");
		chk(dcbo_pkg::REG_STATUS, 32'h6, "line clean");
		op_run(C_ZERO, 8'h00, 32'h64, s);
		`CHK("uncached zero", 32'h2, s & 32'h1e)
		$display("test alignment done");

		wr(dcbo_pkg::REG_DAC, 32'h300);
		fault_case(C_SM, 8'h08, 3'h0, 5'h08);
		fault_case(C_SM, 8'hb8, 3'h0, 5'h04);
		fault_case(C_SM, 8'h30, 3'h0, 5'h00);
		fault_case(C_SM, 8'hc8, 3'h0, 5'h00);
		fault_case(C_SM, 8'h00, 3'h4, 5'h10);
		fault_case(C_SM, 8'h00, 3'h2, 5'h00);
		fault_case(C_TCH, 8'h09, 3'h0, 5'h00);
		fault_case(C_TCH, 8'hb9, 3'h0, 5'h00);
		fault_case(C_TCH, 8'h00, 3'h2, 5'h10);
		fault_case(C_TCH, 8'h00, 3'h4, 5'h00);
		fault_case(C_TST, 8'h00, 3'h2, 5'h10);
		fault_case(C_ZERO, 8'hbb, 3'h0, 5'h04);
		fault_case(C_ZERO, 8'hcb, 3'h0, 5'h04);
		fault_case(C_ZERO, 8'h0b, 3'h0, 5'h08);
		fault_case(C_ZERO, 8'h07, 3'h1, 5'h04);
		fault_case(C_ZERO, 8'h07, 3'h0, 5'h00);
		fault_case(C_ZERO, 8'h03, 3'h4, 5'h10);
		fault_case(C_ZERO, 8'h03, 3'h2, 5'h00);
		$display("test exceptions done");
		summarize();
	end
endmodule
`default_nettype wire
